// ### verilog/cwoc_pkg.sv
// Package: register map, field layout, reset values and carrier types of the clock wait/oscillator control
package cwoc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAIT_EXIT  = 8'h09;
  localparam logic [7:0] IDX_STOP_DET   = 8'h0c;
  localparam logic [7:0] IDX_FAST_CTRL  = 8'h23;
  localparam logic [7:0] IDX_TRIM_LO    = 8'h24;
  localparam logic [7:0] IDX_FAST_DIV   = 8'h25;
  localparam logic [7:0] IDX_FACT_LO    = 8'h29;
  localparam logic [7:0] IDX_FACT_HI    = 8'h2a;
  localparam logic [7:0] IDX_TRIM_HI    = 8'h2f;
  localparam logic [7:0] IDX_SYS_AUX    = 8'h3e;
  localparam logic [7:0] IDX_PROTECT    = 8'h3f;

  // Wait and exit clock control fields
  localparam int B_WAIT      = 0;
  localparam int B_PIN_ASGN  = 2;
  localparam int B_NODIV     = 5;
  localparam int B_EXIT_LO   = 6;
  // Stop detection fields
  localparam int B_DET_EN    = 0;
  localparam int B_DET_IRQ   = 1;
  localparam int B_ONCHIP    = 2;
  localparam int B_MON       = 3;
  // Fast oscillator control fields
  localparam int B_FAST_EN   = 0;
  localparam int B_FAST_SEL  = 1;
  localparam int B_D128_SRC  = 3;
  localparam int B_PDIV_LO   = 0;
  // Auxiliary system clock fields
  localparam int B_MOSC_STOP = 0;
  localparam int B_PIN_FUNC  = 1;
  localparam int B_DIV8      = 2;
  localparam int B_CDIV_LO   = 3;
  localparam int B_SOSC_STOP = 5;
  // Protect register field
  localparam int B_CLK_WP    = 0;

  // Exit clock choices
  localparam logic [1:0] EXIT_KEEP = 2'h0;
  localparam logic [1:0] EXIT_FAST = 2'h2;
  localparam logic [1:0] EXIT_MAIN = 2'h3;

  // Reset values
  localparam logic [7:0] RST_WAIT_EXIT = 8'h00;
  localparam logic [7:0] RST_STOP_DET  = 8'h04;
  localparam logic [7:0] RST_FAST_CTRL = 8'h00;
  localparam logic [7:0] RST_FAST_DIV  = 8'h00;
  localparam logic [7:0] RST_SYS_AUX   = 8'h01;
  localparam logic [7:0] RST_PROTECT   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       cpu_clk_run;
    logic       wait_active;
    logic       pins_to_sub;
    logic       main_osc_run;
    logic       pin_is_osc;
    logic       onchip_sel;
    logic       slow_osc_run;
    logic       fast_osc_en;
    logic       fast_osc_sel;
    logic       div128_src;
    logic [2:0] postdiv;
    logic       cpu_div8;
    logic [1:0] cpu_div;
    logic [7:0] trim_lo;
    logic [7:0] trim_hi;
  } cwoc_ctrl_t;

  typedef struct packed {
    logic        aw_have;
    logic        w_have;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic        wait_b;
    logic        pin_asgn;
    logic        nodiv;
    logic [1:0]  exit_sel;
    logic        det_en;
    logic        det_irq;
    logic        onchip;
    logic        fast_en;
    logic        fast_sel;
    logic        d128_src;
    logic [2:0]  postdiv;
    logic [7:0]  trim_lo;
    logic [7:0]  trim_hi;
    logic        clk_wp;
    logic        mosc_stop;
    logic        pin_func;
    logic        div8;
    logic [1:0]  cdiv;
    logic        sosc_stop;
    logic        stop_prev;
    logic        irq;
    logic [2:0]  div_cnt;
    logic        div_tick;
  } cwoc_state_t;

endpackage : cwoc_pkg

// ### verilog/cwoc_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module cwoc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : cwoc_sync

// ### verilog/cwoc_top.sv
// Clock wait, exit clock, stop detection and fast oscillator control with AXI4-Lite registers
// Summary of operation
// - Wait bit set halts CPU clock only
// - Reset or interrupt exits wait, clears bit
// - Pin bit routes shared pins main/sub
// - Wait entry with nodiv forces undivided CPU
// - Exit clock field picks clock on exit
// - Exit code 10 enables/selects fast oscillator
// - Exit code 11 restarts and selects main
// - Detected stop with 11b forces on-chip select
// - Monitor flag set blocks register writes clearing on-chip select
// - Monitor flag shows stop, zero when disabled
// - On-chip select forces slow oscillator on
// - Divide-by-128 source slow or fast clock
// - Post-divider divides by field plus one
// - Trim resets to 20 MHz; factory bytes readable
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cwoc_top
  import cwoc_pkg::*;
#(
  parameter logic [7:0] TRIM20_LO = 8'h80,  // Arbitrary value
  parameter logic [7:0] TRIM20_HI = 8'h40,  // Arbitrary value
  parameter logic [7:0] TRIM18_LO = 8'h7a,  // Arbitrary value
  parameter logic [7:0] TRIM18_HI = 8'h3c   // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        main_osc_stopped_i,
  input  wire logic        periph_irq_i,
  input  wire logic        lowpower_exit_i,
  output cwoc_pkg::cwoc_ctrl_t ctrl_o,
  output logic             osc_stop_irq_o,
  output logic             fast_div_tick_o
);
  import cwoc_pkg::*;

  logic        rst_meta_q;
  logic        rst_n;
  logic        stop_s;
  cwoc_state_t s_q;
  cwoc_state_t s_d;
  logic        mon;
  logic        wr_fire;
  logic        wr_ok;
  logic [7:0]  wr_idx;
  logic        wait_enter;
  logic        exit_ev;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic [7:0]  ar_idx;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  cwoc_sync #(
    .W (1)
  ) u_stop_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (main_osc_stopped_i),
    .q_o     (stop_s)
  );

  assign mon    = s_q.det_en & stop_s;
  assign ar_idx = {2'b00, s_axi_araddr[7:2]};

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      IDX_WAIT_EXIT: rd_val = {s_q.exit_sel, s_q.nodiv, 2'b00, s_q.pin_asgn, 1'b0, s_q.wait_b};
      IDX_STOP_DET:  rd_val = {4'h0, mon, s_q.onchip, s_q.det_irq, s_q.det_en};
      IDX_FAST_CTRL: rd_val = {4'h0, s_q.d128_src, 1'b0, s_q.fast_sel, s_q.fast_en};
      IDX_TRIM_LO:   rd_val = s_q.trim_lo;
      IDX_FAST_DIV:  rd_val = {5'h00, s_q.postdiv};
      IDX_FACT_LO:   rd_val = TRIM18_LO;
      IDX_FACT_HI:   rd_val = TRIM18_HI;
      IDX_TRIM_HI:   rd_val = s_q.trim_hi;
      IDX_SYS_AUX:   rd_val = {2'b00, s_q.sosc_stop, s_q.cdiv, s_q.div8, s_q.pin_func, s_q.mosc_stop};
      IDX_PROTECT:   rd_val = {7'h00, s_q.clk_wp};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d        = s_q;
    wr_idx     = {2'b00, s_q.waddr[7:2]};
    wr_fire    = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
    wr_ok      = 1'b1;
    wait_enter = 1'b0;
    exit_ev    = 1'b0;

    // Bus handshakes
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Register writes
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (s_q.wlane0) begin
        unique case (wr_idx)
          IDX_WAIT_EXIT: begin
            wait_enter   = s_q.wdata[B_WAIT] & ~s_q.wait_b;
            s_d.wait_b   = s_q.wdata[B_WAIT];
            s_d.pin_asgn = s_q.wdata[B_PIN_ASGN];
            s_d.nodiv    = s_q.wdata[B_NODIV];
            s_d.exit_sel = s_q.wdata[B_EXIT_LO +: 2];
          end
          IDX_STOP_DET: begin
            if (s_q.clk_wp) begin
              s_d.det_en  = s_q.wdata[B_DET_EN];
              s_d.det_irq = s_q.wdata[B_DET_IRQ];
              if (s_q.wdata[B_ONCHIP] || !mon) begin
                s_d.onchip = s_q.wdata[B_ONCHIP];
              end
            end
          end
          IDX_FAST_CTRL: begin
            if (s_q.clk_wp) begin
              s_d.fast_en  = s_q.wdata[B_FAST_EN];
              s_d.fast_sel = s_q.wdata[B_FAST_SEL];
              s_d.d128_src = s_q.wdata[B_D128_SRC];
            end
          end
          IDX_FAST_DIV: begin
            if (s_q.clk_wp) begin
              s_d.postdiv = s_q.wdata[B_PDIV_LO +: 3];
            end
          end
          IDX_TRIM_LO: begin
            if (s_q.clk_wp) begin
              s_d.trim_lo = s_q.wdata;
            end
          end
          IDX_TRIM_HI: begin
            if (s_q.clk_wp) begin
              s_d.trim_hi = s_q.wdata;
            end
          end
          IDX_SYS_AUX: begin
            if (s_q.clk_wp) begin
              s_d.mosc_stop = s_q.wdata[B_MOSC_STOP];
              s_d.pin_func  = s_q.pin_func | s_q.wdata[B_PIN_FUNC];
              s_d.div8      = s_q.wdata[B_DIV8];
              s_d.cdiv      = s_q.wdata[B_CDIV_LO +: 2];
              s_d.sosc_stop = s_q.wdata[B_SOSC_STOP];
            end
          end
          IDX_PROTECT: begin
            s_d.clk_wp = s_q.wdata[B_CLK_WP];
          end
          IDX_FACT_LO, IDX_FACT_HI: begin
            wr_ok = 1'b1;
          end
          default: begin
            wr_ok = 1'b0;
          end
        endcase
      end else if (!(wr_idx inside {IDX_WAIT_EXIT, IDX_STOP_DET, IDX_FAST_CTRL, IDX_TRIM_LO,
                                    IDX_FAST_DIV, IDX_FACT_LO, IDX_FACT_HI, IDX_TRIM_HI,
                                    IDX_SYS_AUX, IDX_PROTECT})) begin
        wr_ok = 1'b0;
      end
      s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Wait entry with no-division request
    if (wait_enter && s_d.nodiv) begin
      s_d.div8 = 1'b0;
      s_d.cdiv = 2'b00;
    end

    // Interrupt exit from wait, or exit from stop / power-off 2
    if (s_q.wait_b && periph_irq_i) begin
      s_d.wait_b = 1'b0;
      exit_ev    = 1'b1;
    end
    if (lowpower_exit_i) begin
      s_d.wait_b = 1'b0;
      exit_ev    = 1'b1;
    end
    if (exit_ev) begin
      unique case (s_q.exit_sel)
        EXIT_FAST: begin
          s_d.onchip   = 1'b1;
          s_d.fast_en  = 1'b1;
          s_d.fast_sel = 1'b1;
        end
        EXIT_MAIN: begin
          s_d.mosc_stop = 1'b0;
          s_d.pin_func  = 1'b1;
          s_d.onchip    = 1'b0;
        end
        default: begin
          s_d.onchip = s_d.onchip;  // Previous clock kept; reserved code changes nothing
        end
      endcase
    end

    // Stop detection fallback and interrupt request
    if (stop_s && s_q.det_en && s_q.det_irq) begin
      s_d.onchip = 1'b1;
    end
    s_d.stop_prev = stop_s;
    s_d.irq       = stop_s & ~s_q.stop_prev & s_q.det_en & s_q.det_irq;

    if (s_d.onchip) begin
      s_d.sosc_stop = 1'b0;
    end

    // Fast clock post-divider
    s_d.div_tick = 1'b0;
    if (!s_q.fast_en) begin
      s_d.div_cnt = 3'h0;
    end else if (s_q.div_cnt >= s_q.postdiv) begin
      s_d.div_cnt  = 3'h0;
      s_d.div_tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.wait_b    <= RST_WAIT_EXIT[B_WAIT];
      s_q.onchip    <= RST_STOP_DET[B_ONCHIP];
      s_q.fast_en   <= RST_FAST_CTRL[B_FAST_EN];
      s_q.postdiv   <= RST_FAST_DIV[2:0];
      s_q.trim_lo   <= TRIM20_LO;
      s_q.trim_hi   <= TRIM20_HI;
      s_q.mosc_stop <= RST_SYS_AUX[B_MOSC_STOP];
      s_q.clk_wp    <= RST_PROTECT[B_CLK_WP];
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_have & ~s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = {24'h00_0000, s_q.rdata};
  assign s_axi_rresp   = s_q.rresp;

  always_comb begin
    ctrl_o.cpu_clk_run  = ~s_q.wait_b;
    ctrl_o.wait_active  = s_q.wait_b;
    ctrl_o.pins_to_sub  = s_q.pin_asgn;
    ctrl_o.main_osc_run = ~s_q.mosc_stop;
    ctrl_o.pin_is_osc   = s_q.pin_func;
    ctrl_o.onchip_sel   = s_q.onchip;
    ctrl_o.slow_osc_run = ~s_q.sosc_stop;
    ctrl_o.fast_osc_en  = s_q.fast_en;
    ctrl_o.fast_osc_sel = s_q.fast_sel;
    ctrl_o.div128_src   = s_q.d128_src;
    ctrl_o.postdiv      = s_q.postdiv;
    ctrl_o.cpu_div8     = s_q.div8;
    ctrl_o.cpu_div      = s_q.cdiv;
    ctrl_o.trim_lo      = s_q.trim_lo;
    ctrl_o.trim_hi      = s_q.trim_hi;
  end
  assign osc_stop_irq_o  = s_q.irq;
  assign fast_div_tick_o = s_q.div_tick;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_wait_gates_cpu: assert property (s_q.wait_b |-> !ctrl_o.cpu_clk_run && ctrl_o.slow_osc_run | s_q.onchip == 1'b0)
    else $error("CPU clock runs during wait");
  a_irq_ends_wait: assert property (s_q.wait_b && periph_irq_i |=> !s_q.wait_b)
    else $error("Wait not left on interrupt");
  a_nodiv_on_entry: assert property (wait_enter && s_d.nodiv |=> s_q.cdiv == 2'b00 && !s_q.div8 && s_q.wait_b)
    else $error("CPU divider not cleared on wait entry");
  a_exit_fast_set: assert property (exit_ev && s_q.exit_sel == EXIT_FAST |=> s_q.onchip && s_q.fast_en && s_q.fast_sel)
    else $error("Fast exit bits not set");
  a_exit_main_set: assert property (exit_ev && s_q.exit_sel == EXIT_MAIN && !(stop_s && s_q.det_en && s_q.det_irq)
                                    |=> !s_q.mosc_stop && s_q.pin_func && !s_q.onchip)
    else $error("Main exit bits not set");
  a_stop_forces_onchip: assert property (stop_s && s_q.det_en && s_q.det_irq |=> s_q.onchip)
    else $error("On-chip select not forced on stop");
  a_mon_holds_select: assert property (mon && s_q.onchip && !exit_ev |=> s_q.onchip)
    else $error("On-chip select cleared while monitor set");
  a_mon_zero_off: assert property (!s_q.det_en |-> s_axi_arvalid && s_axi_arready && ar_idx == IDX_STOP_DET
                                   |=> !s_axi_rdata[B_MON])
    else $error("Monitor flag read set while detection off");
  a_onchip_slow_on: assert property (s_q.onchip |-> ctrl_o.slow_osc_run)
    else $error("Slow oscillator off with on-chip select");
  a_protect_blocks: assert property (wr_fire && !s_q.clk_wp && wr_idx == IDX_FAST_DIV |=> $stable(s_q.postdiv))
    else $error("Protected write took effect");
  a_postdiv_period: assert property (s_q.div_tick && s_q.fast_en && s_q.postdiv == 3'h1
                                     ##1 s_q.fast_en && s_q.postdiv == 3'h1 |-> !s_q.div_tick ##1 s_q.div_tick)
    else $error("Post-divider period wrong");
  a_irq_on_detect: assert property ($rose(stop_s) && s_q.det_en && s_q.det_irq |=> osc_stop_irq_o)
    else $error("No stop interrupt request");

endmodule : cwoc_top

// ### dv/cwoc_top_tb.sv
// Self-checking testbench of the clock wait and oscillator control block
`timescale 1ns/100ps
module cwoc_top_tb;
  import cwoc_pkg::*;
  localparam logic [7:0] T20L = 8'h91;  // Arbitrary value
  localparam logic [7:0] T20H = 8'h52;  // Arbitrary value
  localparam logic [7:0] T18L = 8'h6b;  // Arbitrary value
  localparam logic [7:0] T18H = 8'h2d;  // Arbitrary value
  logic        clk_i, arst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, stopped, pirq, lpx, irq_o, tick;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  cwoc_ctrl_t  ctrl;
  int          n_errors, num_checks, cycles;

  cwoc_top #(.TRIM20_LO(T20L), .TRIM20_HI(T20H), .TRIM18_LO(T18L), .TRIM18_HI(T18H)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_osc_stopped_i(stopped), .periph_irq_i(pirq), .lowpower_exit_i(lpx),
    .ctrl_o(ctrl), .osc_stop_irq_o(irq_o), .fast_div_tick_o(tick)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Address and data offered together; each is released at its own handshake edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "write response");
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h00_0000, exp}, "read data");
    chk(32'(rresp), 32'(er), "read response");
  endtask : rd

  task automatic pulse(input logic sel);
    @(posedge clk_i);
    if (sel) begin
      pirq <= 1'b1;
    end else begin
      lpx <= 1'b1;
    end
    @(posedge clk_i);
    pirq <= 1'b0;
    lpx <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  task automatic t_reset;
    chk(ctrl.cpu_clk_run & ctrl.onchip_sel & ctrl.slow_osc_run, 1, "reset clocks on");
    chk(ctrl.main_osc_run, 0, "reset main stopped");
    rd(IDX_WAIT_EXIT, RST_WAIT_EXIT, RESP_OKAY);
    rd(IDX_STOP_DET, RST_STOP_DET, RESP_OKAY);
    rd(IDX_FAST_CTRL, RST_FAST_CTRL, RESP_OKAY);
    rd(IDX_FAST_DIV, RST_FAST_DIV, RESP_OKAY);
    rd(IDX_TRIM_LO, T20L, RESP_OKAY);
    rd(IDX_TRIM_HI, T20H, RESP_OKAY);
  endtask : t_reset

  task automatic t_protect;
    wr(8'h10, 8'hff, RESP_SLVERR);
    rd(8'h10, 8'h00, RESP_SLVERR);
    wr(IDX_FAST_DIV, 8'h05, RESP_OKAY);
    rd(IDX_FAST_DIV, 8'h00, RESP_OKAY);
    wr(IDX_PROTECT, 8'h01, RESP_OKAY);
    wr(IDX_FAST_DIV, 8'h05, RESP_OKAY);
    rd(IDX_FAST_DIV, 8'h05, RESP_OKAY);
    wr(IDX_FACT_LO, 8'h00, RESP_OKAY);
    rd(IDX_FACT_LO, T18L, RESP_OKAY);
    rd(IDX_FACT_HI, T18H, RESP_OKAY);
    wr(IDX_TRIM_LO, T18L, RESP_OKAY);
    wr(IDX_TRIM_HI, T18H, RESP_OKAY);
    chk({ctrl.trim_hi, ctrl.trim_lo}, {T18H, T18L}, "trim copied");
  endtask : t_protect

  task automatic t_pins;
    wr(IDX_WAIT_EXIT, 8'h06, RESP_OKAY);
    rd(IDX_WAIT_EXIT, 8'h04, RESP_OKAY);
    chk(ctrl.pins_to_sub, 1, "pins to sub");
    wr(IDX_WAIT_EXIT, 8'h00, RESP_OKAY);
    chk(ctrl.pins_to_sub, 0, "pins to main");
  endtask : t_pins

  task automatic t_exit_main;
    wr(IDX_SYS_AUX, 8'h05, RESP_OKAY);
    wr(IDX_WAIT_EXIT, 8'hc1, RESP_OKAY);
    chk({ctrl.cpu_clk_run, ctrl.wait_active, ctrl.slow_osc_run}, 3'b011, "wait entry");
    pulse(1'b0);
    chk(ctrl.main_osc_run & ctrl.pin_is_osc, 1, "main restarted");
    chk(ctrl.onchip_sel, 0, "main selected");
    chk(ctrl.cpu_clk_run, 1, "cpu clock back");
    chk(ctrl.cpu_div8, 1, "divide-by-8 kept");
  endtask : t_exit_main

  task automatic t_exit_fast;
    wr(IDX_SYS_AUX, 8'h1e, RESP_OKAY);
    chk({ctrl.cpu_div8, ctrl.cpu_div}, 3'b111, "divider set");
    wr(IDX_WAIT_EXIT, 8'ha1, RESP_OKAY);
    chk({ctrl.cpu_div8, ctrl.cpu_div}, 3'b000, "undivided");
    pulse(1'b1);
    chk({ctrl.onchip_sel, ctrl.fast_osc_en, ctrl.fast_osc_sel}, 3'b111, "fast exit");
    chk(ctrl.cpu_clk_run, 1, "interrupt exit");
    rd(IDX_WAIT_EXIT, 8'ha0, RESP_OKAY);
    wr(IDX_WAIT_EXIT, 8'h00, RESP_OKAY);
  endtask : t_exit_fast

  task automatic t_stop_det;
    int hits;
    hits = 0;
    wr(IDX_STOP_DET, 8'h03, RESP_OKAY);
    chk(ctrl.onchip_sel, 0, "main clock chosen");
    @(posedge clk_i);
    stopped <= 1'b1;
    repeat (8) begin
      @(posedge clk_i);
      if (irq_o === 1'b1) hits++;
    end
    chk(32'(hits), 1, "one stop request");
    chk(ctrl.onchip_sel, 1, "fallback");
    rd(IDX_STOP_DET, 8'h0f, RESP_OKAY);
    wr(IDX_STOP_DET, 8'h01, RESP_OKAY);
    rd(IDX_STOP_DET, 8'h0d, RESP_OKAY);
    wr(IDX_SYS_AUX, 8'h3e, RESP_OKAY);
    chk(ctrl.slow_osc_run, 1, "slow forced on");
    wr(IDX_STOP_DET, 8'h00, RESP_OKAY);
    rd(IDX_STOP_DET, 8'h04, RESP_OKAY);
    stopped <= 1'b0;
  endtask : t_stop_det

  task automatic t_postdiv;
    int n;
    logic [2:0] dv [4];
    dv = '{3'h0, 3'h1, 3'h3, 3'h7};
    foreach (dv[i]) begin
      wr(IDX_FAST_DIV, {5'h00, dv[i]}, RESP_OKAY);
      chk(32'(ctrl.postdiv), 32'(dv[i]), "postdiv field");
      repeat (2) do @(posedge clk_i); while (tick !== 1'b1);
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (tick !== 1'b1);
      chk(32'(n), 32'(dv[i]) + 1, "tick spacing");
    end
    wr(IDX_FAST_CTRL, 8'h0b, RESP_OKAY);
    chk(ctrl.div128_src, 1, "fast source");
    wr(IDX_FAST_CTRL, 8'h03, RESP_OKAY);
    chk(ctrl.div128_src, 0, "slow source");
    wr(IDX_FAST_CTRL, 8'h01, RESP_OKAY);
    chk(ctrl.fast_osc_sel, 0, "fast deselected");
    wr(IDX_FAST_CTRL, 8'h00, RESP_OKAY);
    chk(ctrl.fast_osc_en, 0, "fast disabled");
  endtask : t_postdiv

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      summarize();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, stopped, pirq, lpx} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    arst_n_i = 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_protect();
    t_pins();
    t_exit_main();
    t_exit_fast();
    t_stop_det();
    t_postdiv();
    summarize();
  end
endmodule : cwoc_top_tb
